// ===== pkg/mic_pkg.sv
// package: constants and types for motion input conditioning
package mic_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int FILT_STEP_US = 200;
  localparam int FILT_STEP_CYC = (CLK_HZ / 1_000_000) * FILT_STEP_US;
  localparam logic [5:0] FILT_MIN_SEL = 6'h01;
  localparam logic [6:0] FILT_MAX_SEL = 7'h40;
  localparam logic [5:0] FILT_DEF_SEL = 6'h20;
  localparam int FILT_CNT_W = 21;
  localparam logic [2:0] SLOT_MAX = 3'h6;
  localparam int NUM_FILT = 4;
  localparam int IDX_STOP = 0;
  localparam int IDX_HOME = 1;
  localparam int IDX_UPPER = 2;
  localparam int IDX_LOWER = 3;

  typedef enum logic [1:0] {
    MIC_RESP_IGNORE = 2'h0,
    MIC_RESP_DECEL  = 2'h1,
    MIC_RESP_IMMED  = 2'h2
  } mic_resp_t;

  typedef enum logic [2:0] {
    MIC_ST_IDLE  = 3'b001,
    MIC_ST_DECEL = 3'b010,
    MIC_ST_HALT  = 3'b100
  } mic_state_t;

  typedef struct packed {
    logic stop_request_input;
    logic home_switch_input;
    logic upper_travel_limit;
    logic lower_travel_limit;
    logic zero_pulse_input;
  } mic_inputs_t;

  typedef struct packed {
    logic      active_low_stop;
    logic      active_low_home;
    logic      active_low_upper;
    logic      active_low_lower;
    logic      active_low_zero;
    logic [5:0] filt_sel;
    mic_resp_t resp_upper;
    mic_resp_t resp_lower;
    mic_resp_t resp_stop;
    logic      pulse_pol_neg;
    logic      dir_two_pulse;
    logic      units_eng;
    logic [2:0] slot_addr;
  } mic_cfg_t;
endpackage

// ===== core/mic_filter.sv
// module: one input debounce filter with programmable stable time
`timescale 1ns/1ps
`default_nettype none
module mic_filter
  import mic_pkg::*;
(
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // sample and time
  input  wire logic                  raw,
  input  wire logic [FILT_CNT_W-1:0] limit,
  // result
  output logic                       filt
);
  logic [FILT_CNT_W-1:0] cnt_q;
  logic                  filt_q;
  wire                   differs = raw != filt_q;
  wire                   expired = cnt_q + FILT_CNT_W'(1) >= limit;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end else if (!differs) begin
      cnt_q <= '0;
    end else if (expired) begin
      cnt_q  <= '0;
      filt_q <= raw;
    end else begin
      cnt_q <= cnt_q + FILT_CNT_W'(1);
    end
  end
  assign filt = filt_q;
endmodule
`default_nettype wire

// ===== core/mic_top.sv
// module: input conditioning and stop response for one pulse axis
`timescale 1ns/1ps
`default_nettype none
module mic_top
  import mic_pkg::*;
(
  // clock and reset
  input  wire logic             REF_CLK,
  input  wire logic             RST,
  // field inputs, 1 while current flows
  input  wire mic_pkg::mic_inputs_t FIELD_IN,
  // configuration
  input  wire mic_pkg::mic_cfg_t CFG,
  input  wire logic [2:0]       SLOT_SEL,
  // control from controller
  input  wire logic             AXIS_ENABLE_CALL,
  input  wire logic             MOTION_REQ,
  input  wire logic             MOTION_DIR_POS,
  input  wire logic             PULSE_TICK,
  input  wire logic             DECEL_DONE,
  // conditioned inputs and registered raw lamp copies
  output mic_pkg::mic_inputs_t  COND_IN,
  output mic_pkg::mic_inputs_t  LAMP_OUT,
  // status
  output logic                  SELECTED,
  output logic                  MOVING,
  output logic                  DECEL_REQ,
  output logic                  IMMED_STOP,
  output logic                  UNITS_ENG,
  // pulse outputs
  output logic                  PULSE_LINE_FIRST,
  output logic                  PULSE_LINE_SECOND,
  output logic                  PULSE_FIRST_DIFF_P,
  output logic                  PULSE_FIRST_DIFF_N,
  output logic                  PULSE_SECOND_DIFF_P,
  output logic                  PULSE_SECOND_DIFF_N
);
  import mic_pkg::*;

  function automatic logic [FILT_CNT_W-1:0] filt_cycles(input logic [5:0] sel);
    logic [6:0] s;
    // 64 steps do not fit the 6-bit field, so code zero stands for the longest time
    s = (sel == '0) ? FILT_MAX_SEL : {1'b0, sel};
    filt_cycles = FILT_CNT_W'(s) * FILT_CNT_W'(FILT_STEP_CYC);
  endfunction

  function automatic logic [1:0] resp_act(input mic_resp_t r, input logic hit);
    resp_act = {hit && r == MIC_RESP_IMMED, hit && r == MIC_RESP_DECEL};
  endfunction

  // level selection
  wire [4:0] raw_v = FIELD_IN;
  wire [4:0] inv_v = {CFG.active_low_stop, CFG.active_low_home, CFG.active_low_upper,
                      CFG.active_low_lower, CFG.active_low_zero};
  wire [4:0] lvl_v = raw_v ^ inv_v;
  wire [FILT_CNT_W-1:0] limit = filt_cycles(CFG.filt_sel);
  wire [3:0] filt_v;

  // stop, home and both limits are filtered; the order follows the struct top bits
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILT; gi++) begin : g_filt
      mic_filter u_filt (
        .clk   (REF_CLK),
        .rst   (RST),
        .raw   (lvl_v[4-gi]),
        .limit (limit),
        .filt  (filt_v[3-gi])
      );
    end
  endgenerate

  wire stop_a  = filt_v[3];
  wire upper_a = filt_v[1];
  wire lower_a = filt_v[0];

  // stop response; limits only stop motion heading into them
  wire [1:0] act_s = resp_act(CFG.resp_stop, stop_a);
  wire [1:0] act_u = resp_act(CFG.resp_upper, upper_a && MOTION_DIR_POS);
  wire [1:0] act_l = resp_act(CFG.resp_lower, lower_a && !MOTION_DIR_POS);
  wire immed_hit = act_s[1] | act_u[1] | act_l[1];
  wire decel_hit = act_s[0] | act_u[0] | act_l[0];
  // a missing enable call also stops at once, controller must call every scan
  wire enabled = AXIS_ENABLE_CALL;
  wire selected = (SLOT_SEL <= SLOT_MAX) && (CFG.slot_addr == SLOT_SEL);

  mic_state_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      MIC_ST_IDLE:
        if (MOTION_REQ && enabled && !immed_hit && !decel_hit) st_d = MIC_ST_DECEL;
      MIC_ST_DECEL:
        if (!enabled || immed_hit) st_d = MIC_ST_HALT;
        else if (decel_hit) st_d = MIC_ST_HALT;
      MIC_ST_HALT:
        if (!MOTION_REQ) st_d = MIC_ST_IDLE;
      default: st_d = MIC_ST_IDLE;
    endcase
  end

  // running is the DECEL code reused as "moving"; decel request holds until done
  logic decel_q;
  wire moving = st_q == MIC_ST_DECEL;
  wire go_decel = moving && enabled && !immed_hit && decel_hit;
  wire decel_d = (decel_q && !DECEL_DONE) || go_decel;
  wire pulse_now = moving && PULSE_TICK && !decel_q && !immed_hit;

  // direction method: pulse+dir, or pulse on one line per direction
  wire line1 = CFG.dir_two_pulse ? (pulse_now && MOTION_DIR_POS) : pulse_now;
  wire line2 = CFG.dir_two_pulse ? (pulse_now && !MOTION_DIR_POS) : MOTION_DIR_POS;
  wire p1 = line1 ^ CFG.pulse_pol_neg;
  wire p2 = line2 ^ CFG.pulse_pol_neg;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      st_q    <= MIC_ST_IDLE;
      decel_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      decel_q <= decel_d;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      COND_IN             <= '0;
      LAMP_OUT            <= '0;
      SELECTED            <= 1'b0;
      MOVING              <= 1'b0;
      DECEL_REQ           <= 1'b0;
      IMMED_STOP          <= 1'b0;
      UNITS_ENG           <= 1'b0;
      PULSE_LINE_FIRST    <= 1'b0;
      PULSE_LINE_SECOND   <= 1'b0;
      PULSE_FIRST_DIFF_P  <= 1'b0;
      PULSE_FIRST_DIFF_N  <= 1'b1;
      PULSE_SECOND_DIFF_P <= 1'b0;
      PULSE_SECOND_DIFF_N <= 1'b1;
    end else begin
      COND_IN             <= {filt_v, lvl_v[0]};
      LAMP_OUT            <= FIELD_IN;
      SELECTED            <= selected;
      MOVING              <= moving;
      DECEL_REQ           <= decel_d;
      IMMED_STOP          <= moving && (immed_hit || !enabled);
      UNITS_ENG           <= CFG.units_eng;
      PULSE_LINE_FIRST    <= p1;
      PULSE_LINE_SECOND   <= p2;
      PULSE_FIRST_DIFF_P  <= p1;
      PULSE_FIRST_DIFF_N  <= !p1;
      PULSE_SECOND_DIFF_P <= p2;
      PULSE_SECOND_DIFF_N <= !p2;
    end
  end
endmodule
`default_nettype wire

// ===== verif/mic_asserts.sv
// checker: port-level properties of the input conditioning block
`timescale 1ns/1ps
`default_nettype none
module mic_asserts
  import mic_pkg::*;
(
  // clock and reset
  input wire logic                REF_CLK,
  input wire logic                RST,
  // inputs
  input wire mic_pkg::mic_inputs_t FIELD_IN,
  input wire mic_pkg::mic_cfg_t   CFG,
  input wire logic [2:0]          SLOT_SEL,
  input wire logic                AXIS_ENABLE_CALL,
  // outputs
  input wire mic_pkg::mic_inputs_t COND_IN,
  input wire mic_pkg::mic_inputs_t LAMP_OUT,
  input wire logic                SELECTED,
  input wire logic                MOVING,
  input wire logic                IMMED_STOP,
  input wire logic                UNITS_ENG,
  input wire logic                PULSE_LINE_FIRST,
  input wire logic                PULSE_FIRST_DIFF_P,
  input wire logic                PULSE_FIRST_DIFF_N,
  input wire logic                PULSE_LINE_SECOND,
  input wire logic                PULSE_SECOND_DIFF_P,
  input wire logic                PULSE_SECOND_DIFF_N
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (RST);
  lamp_follow_a: assert property (!$past(RST) |-> LAMP_OUT == $past(FIELD_IN))
    else $error("lamp differs from raw input");
  diff_true_a: assert property (PULSE_FIRST_DIFF_P == PULSE_LINE_FIRST)
    else $error("differential pulse differs from line");
  diff_pair_a: assert property (PULSE_FIRST_DIFF_N == !PULSE_FIRST_DIFF_P)
    else $error("differential pair not inverse");
  second_pair_a: assert property (PULSE_SECOND_DIFF_P == PULSE_LINE_SECOND &&
    PULSE_SECOND_DIFF_N == !PULSE_SECOND_DIFF_P)
    else $error("second differential pair wrong");
  units_sel_a: assert property (!$past(RST) |-> UNITS_ENG == $past(CFG.units_eng))
    else $error("units flag wrong");
  // raw must already hold the new level two edges before the flip
  stop_filter_a: assert property ($changed(COND_IN.stop_request_input) |->
    COND_IN.stop_request_input == $past(FIELD_IN.stop_request_input ^ CFG.active_low_stop, 2))
    else $error("stop changed without stable raw level");
  slot_match_a: assert property (!$past(RST) |-> SELECTED ==
    ($past(SLOT_SEL) == $past(CFG.slot_addr) && $past(SLOT_SEL) <= 3'h6))
    else $error("slot selection wrong");
  immed_halt_a: assert property ($rose(IMMED_STOP) |=> !MOVING)
    else $error("still moving after immediate stop");
  enable_loss_a: assert property (!AXIS_ENABLE_CALL |-> ##2 !MOVING)
    else $error("moving without enable");
endmodule
`default_nettype wire

// ===== verif/mic_drive_model.sv
// partner: motor driver counting pulses and finishing ramps
`timescale 1ns/1ps
`default_nettype none
module mic_drive_model (
  // clock
  input  wire logic clk,
  // from the axis
  input  wire logic first,
  input  wire logic second,
  input  wire logic decel_req,
  // to the bench and axis
  output logic      decel_done,
  output int        cnt_a,
  output int        cnt_b
);
  logic       a_q;
  logic       b_q;
  logic [3:0] wait_q;
  initial begin
    {a_q, b_q, decel_done, wait_q} = '0;
    cnt_a = 0;
    cnt_b = 0;
  end
  // slow ramp so the request is seen standing
  always @(posedge clk) begin
    a_q <= first;
    b_q <= second;
    if (first && !a_q) cnt_a <= cnt_a + 1;
    if (second && !b_q) cnt_b <= cnt_b + 1;
    wait_q <= (decel_req && !decel_done) ? wait_q + 4'h1 : 4'h0;
    decel_done <= decel_req && wait_q == 4'h9;
  end
endmodule
`default_nettype wire

// ===== verif/tb_motion_input_conditioning.sv
// testbench: conditioning, filter and stop response of one axis
`timescale 1ns/1ps
`default_nettype none
module tb_motion_input_conditioning;
  import mic_pkg::*;
  logic        clk = 0, rst = 1, en = 1, req = 0, dir = 1, tick = 0;
  logic        sel, moving, decel, immed, units, done, l1, l2;
  logic [2:0]  slot = 3'h3;
  mic_inputs_t field = '0, cond, lamp;
  mic_cfg_t    cfg = '0;
  int          fail_count = 0, checks = 0, ca, cb, n0;
  always #5 clk = ~clk;
  mic_top dut (.REF_CLK(clk), .RST(rst), .FIELD_IN(field), .CFG(cfg), .SLOT_SEL(slot),
    .AXIS_ENABLE_CALL(en), .MOTION_REQ(req), .MOTION_DIR_POS(dir), .PULSE_TICK(tick),
    .DECEL_DONE(done), .COND_IN(cond), .LAMP_OUT(lamp), .SELECTED(sel), .MOVING(moving),
    .DECEL_REQ(decel), .IMMED_STOP(immed), .UNITS_ENG(units), .PULSE_LINE_FIRST(l1),
    .PULSE_LINE_SECOND(l2), .PULSE_FIRST_DIFF_P(), .PULSE_FIRST_DIFF_N(),
    .PULSE_SECOND_DIFF_P(), .PULSE_SECOND_DIFF_N());
  mic_drive_model drv (.clk(clk), .first(l1), .second(l2), .decel_req(decel),
    .decel_done(done), .cnt_a(ca), .cnt_b(cb));
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      tick = 1;
      cyc(1);
      tick = 0;
      cyc(1);
    end
  endtask
  // rise with one filter setting, fall with another, to keep the run short
  task automatic filt(input int s_on, input int s_off);
    cfg.filt_sel = s_on[5:0];
    field.stop_request_input = 1;
    cyc(2); chk("lamp", 1, lamp.stop_request_input);
    cyc(s_on * FILT_STEP_CYC - 10); chk("early", 0, cond.stop_request_input);
    cyc(20); chk("late", 1, cond.stop_request_input);
    cfg.filt_sel = s_off[5:0];
    field.stop_request_input = 0;
    cyc(s_off * FILT_STEP_CYC - 10); chk("hold", 1, cond.stop_request_input);
    cyc(20); chk("clear", 0, cond.stop_request_input);
  endtask
  task automatic stop_test;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    // lengthy filter times dominate the run
    #1200us;
    fail_count++;
    stop_test();
  end
  initial begin
    {cfg.active_low_home, cfg.units_eng, cfg.slot_addr} = {2'b11, 3'h3};
    cfg.filt_sel = 6'h01;
    cyc(10);
    rst = 0;
    cyc(3); chk("home early", 0, cond.home_switch_input);
    field.stop_request_input = 1;
    cyc(1000);
    field.stop_request_input = 0;
    cyc(1500); chk("glitch", 0, cond.stop_request_input);
    filt(1, 2);
    chk("home", 1, cond.home_switch_input);
    chk("units", 1, units);
    chk("slot", 1, sel);
    {slot, cfg.slot_addr} = 6'h3f;
    cyc(2); chk("slot7", 0, sel);
    cfg.filt_sel = 6'h01;
    req = 1;
    cyc(3); chk("move", 1, moving);
    n0 = ca;
    pulse(2); chk("pulses", n0 + 2, ca);
    // stop stays asserted from here on; only its response is changed
    field.stop_request_input = 1;
    cyc(FILT_STEP_CYC + 8); chk("moving", 1, moving);
    chk("no stop", 0, immed | decel);
    for (int r = 1; r < 3; r++) begin
      {req, cfg.resp_stop} = {1'b1, MIC_RESP_IGNORE};
      cyc(3); chk("ignored", 1, moving);
      cfg.resp_stop = mic_resp_t'(r);
      cyc(1); chk("immed", r == 2, immed);
      chk("decel", r == 1, decel);
      cyc(1); chk("halted", 0, moving);
      req = 0;
      cyc(20);
    end
    cfg.resp_stop = MIC_RESP_IGNORE;
    {cfg.dir_two_pulse, cfg.resp_lower, dir, req} = {1'b1, MIC_RESP_IMMED, 2'b01};
    cyc(3);
    n0 = cb;
    pulse(2); chk("neg pulses", n0 + 2, cb);
    field.lower_travel_limit = 1;
    cyc(FILT_STEP_CYC + 8); chk("limit", 0, moving);
    cfg.pulse_pol_neg = 1;
    cyc(2); chk("polarity", 1, l1);
    cfg.pulse_pol_neg = 0;
    {req, field.lower_travel_limit, cfg.dir_two_pulse, dir} = 4'b0001;
    cyc(20);
    req = 1;
    cyc(3);
    en = 0;
    cyc(2); chk("enable", 0, moving);
    stop_test();
  end
endmodule
bind mic_top mic_asserts u_chk (.*);
`default_nettype wire
